/* include/ipk_pkg.sv */
/*
 * Constants, register map and state codes for the paddle keyer.
 * Assumes a single 25 MHz system clock.
 */
`default_nettype none
package ipk_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int UNIT_MS_WPM = 1200;
	// one centi-unit threshold, scaled by words per minute
	localparam int CENTI_NUM = CLK_HZ / 1000 * UNIT_MS_WPM / 100;
	localparam int DEBOUNCE_US = 1000;
	localparam int DEBOUNCE_CYC = CLK_HZ / 1000000 * DEBOUNCE_US;
	// element figures in hundredths of a unit
	localparam logic [8:0] ELEM_PERIOD = 9'h0C8;
	localparam logic [7:0] WEIGHT_CLASSIC = 8'h64;
	localparam logic [7:0] WEIGHT_SPAN = 8'h32;
	localparam logic [6:0] WPM_MIN = 7'h06;
	localparam logic [6:0] WPM_MAX_STD = 7'h32;
	localparam logic [6:0] WPM_MAX_FAST = 7'h5A;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_SPEED = 4'h4;
	localparam logic [3:0] OFS_WEIGHT = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hC;
	localparam int CTRL_SHORT_MEM = 0;
	localparam int CTRL_LONG_MEM = 1;
	localparam int CTRL_WEIGHT_MODE = 2;
	localparam int WEIGHT_LIGHT_LSB = 8;
	localparam logic [2:0] CTRL_RESET = 3'h3;
	localparam logic [6:0] SPEED_RESET = 7'h14;
	localparam logic [5:0] ADJ_RESET = 6'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ON = 2'b01,
		ST_OFF = 2'b10
	} ipk_state_t;
endpackage
`default_nettype wire

/* hw/ipk_keyer.sv */
/*
 * Iambic paddle keyer with AXI4-Lite control registers.
 * Assumes paddle inputs are active high and may be asynchronous to core_clk_in.
 */
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - short memory catches short paddle during long, short follows it
// - latched short goes between longs, longs then resume while held
// - short memory only, both paddles held gives continuous shorts
// - long first then both, one long then continuous shorts
// - short memory off, short paddle ignored while a long runs
// - long memory catches long paddle during short, long inserted
// - both memories, both paddles held alternate short and long
// - squeeze starts with element of the paddle closed first
// - long is two short periods with the gap kept keyed
// - timebase runs only while an element is being made
// - completion pulse is raised as the sequencer returns to idle, elements self-complete
// - fixed weighting holds the same ratio at every speed
// - fixed weighting, both adjusts zero, gives one unit short
// - auto weighting moves from heavy toward light as speed rises
// - sidetone gate equals keyed output
// - speed 6 to 50 wpm, build option raises top to 90
// - classical short one unit, gap one unit, long three units
// - weighting changes the gap oppositely, period stays constant
module ipk_keyer #(
	parameter bit FAST_SPEED = 1'b0,
	parameter int CENTI_NUM = ipk_pkg::CENTI_NUM,
	parameter int DEBOUNCE_CYC = ipk_pkg::DEBOUNCE_CYC
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rstn_in,
	// paddles and key line
	input wire logic short_paddle_in,
	input wire logic long_paddle_in,
	output logic keyed_output_out,
	output logic sidetone_gate_out,
	// axi4-lite write
	input wire logic [3:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// axi4-lite read
	input wire logic [3:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in
);
	localparam logic [6:0] WPM_MAX =
		FAST_SPEED ? ipk_pkg::WPM_MAX_FAST : ipk_pkg::WPM_MAX_STD;
	localparam int SPAN = int'(WPM_MAX - ipk_pkg::WPM_MIN);
	// rounded up so the top speed lands exactly on the light end
	localparam int RECIP = (65536 + SPAN - 1) / SPAN;

	function automatic logic [7:0] clamp_adj(input logic [5:0] v);
		clamp_adj = ({2'h0, v} > ipk_pkg::WEIGHT_SPAN) ?
			ipk_pkg::WEIGHT_SPAN : {2'h0, v};
	endfunction

	function automatic logic [6:0] clamp_wpm(input logic [6:0] v);
		if (v < ipk_pkg::WPM_MIN) begin
			clamp_wpm = ipk_pkg::WPM_MIN;
		end else if (v > WPM_MAX) begin
			clamp_wpm = WPM_MAX;
		end else begin
			clamp_wpm = v;
		end
	endfunction

	logic [2:0] ctrl_reg;
	logic [6:0] speed_reg;
	logic [5:0] heavy_reg;
	logic [5:0] light_reg;
	logic [1:0] pad_meta_reg;
	logic [1:0] pad_sync_reg;
	logic [1:0] pad_deb_reg;
	logic [31:0] deb_cnt_reg [2];
	logic [7:0] weight_reg;
	logic [19:0] acc_reg;
	logic [8:0] cnt_reg;
	logic [8:0] on_len_reg;
	logic [8:0] off_len_reg;
	ipk_pkg::ipk_state_t state_reg;
	logic elem_long_reg;
	logic last_long_reg;
	logic last_valid_reg;
	logic short_mem_reg;
	logic long_mem_reg;
	logic done_reg;
	logic [3:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic aw_hold_reg;
	logic w_hold_reg;

	// ------------------------------------------------------------
	// paddle synchroniser and debounce
	// ------------------------------------------------------------
	// two flops then hold-off counter
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pad_meta_reg <= 2'h0;
			pad_sync_reg <= 2'h0;
			pad_deb_reg <= 2'h0;
			deb_cnt_reg[0] <= 32'h0;
			deb_cnt_reg[1] <= 32'h0;
		end else begin
			pad_meta_reg <= {long_paddle_in, short_paddle_in};
			pad_sync_reg <= pad_meta_reg;
			for (int i = 0; i < 2; i++) begin
				if (pad_sync_reg[i] == pad_deb_reg[i]) begin
					deb_cnt_reg[i] <= 32'h0;
				end else if (deb_cnt_reg[i] >= 32'(DEBOUNCE_CYC - 1)) begin
					deb_cnt_reg[i] <= 32'h0;
					pad_deb_reg[i] <= pad_sync_reg[i];
				end else begin
					deb_cnt_reg[i] <= deb_cnt_reg[i] + 32'h1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// weighting
	// ------------------------------------------------------------
	logic [6:0] wpm;
	logic [7:0] heavy;
	logic [7:0] light;
	logic [31:0] drop;
	logic [7:0] weight_next;
	always_comb begin
		wpm = clamp_wpm(speed_reg);
		heavy = clamp_adj(heavy_reg);
		light = clamp_adj(light_reg);
		// linear slide from heavy end to light end of speed range
		drop = 32'(heavy + light) * 32'(wpm - ipk_pkg::WPM_MIN) * 32'(RECIP);
		if (ctrl_reg[ipk_pkg::CTRL_WEIGHT_MODE]) begin
			weight_next = ipk_pkg::WEIGHT_CLASSIC + heavy - drop[23:16];
		end else begin
			// fixed ratio, classical when both adjusts zero
			weight_next = ipk_pkg::WEIGHT_CLASSIC + heavy - light;
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			weight_reg <= ipk_pkg::WEIGHT_CLASSIC;
		end else begin
			weight_reg <= weight_next;
		end
	end

	// ------------------------------------------------------------
	// element timebase
	// ------------------------------------------------------------
	logic [19:0] acc_sum;
	logic tick;
	assign acc_sum = acc_reg + {13'h0, wpm};
	assign tick = (state_reg != ipk_pkg::ST_IDLE) && (acc_sum >= 20'(CENTI_NUM));

	// phase restarts at every element start
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			acc_reg <= 20'h0;
		end else if (state_reg == ipk_pkg::ST_IDLE) begin
			acc_reg <= 20'h0;
		end else begin
			acc_reg <= tick ? acc_sum - 20'(CENTI_NUM) : acc_sum;
		end
	end

	// ------------------------------------------------------------
	// element choice
	// ------------------------------------------------------------
	logic short_en;
	logic long_en;
	logic want_s;
	logic want_l;
	logic pick_long;
	always_comb begin
		short_en = ctrl_reg[ipk_pkg::CTRL_SHORT_MEM];
		long_en = ctrl_reg[ipk_pkg::CTRL_LONG_MEM];
		want_s = pad_deb_reg[0] | short_mem_reg;
		want_l = pad_deb_reg[1] | long_mem_reg;
		pick_long = want_l;
		if (want_s && want_l) begin
			if (short_en && long_en) begin
				// alternate, first element follows first paddle
				pick_long = last_valid_reg ? !last_long_reg : 1'b0;
			end else begin
				// short wins with short memory; long wins without
				pick_long = !short_en;
			end
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= ipk_pkg::ST_IDLE;
			cnt_reg <= 9'h0;
			on_len_reg <= 9'h0;
			off_len_reg <= 9'h0;
			elem_long_reg <= 1'b0;
			last_long_reg <= 1'b0;
			last_valid_reg <= 1'b0;
			keyed_output_out <= 1'b0;
			sidetone_gate_out <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
				ipk_pkg::ST_IDLE: begin
					cnt_reg <= 9'h0;
					last_valid_reg <= want_s | want_l;
					if (want_s || want_l) begin
						state_reg <= ipk_pkg::ST_ON;
						elem_long_reg <= pick_long;
						last_long_reg <= pick_long;
						// long keeps the inner gap keyed
						on_len_reg <= pick_long ?
							ipk_pkg::ELEM_PERIOD + {1'b0, weight_reg} :
							{1'b0, weight_reg};
						off_len_reg <= ipk_pkg::ELEM_PERIOD - {1'b0, weight_reg};
						keyed_output_out <= 1'b1;
						sidetone_gate_out <= 1'b1;
					end
				end
				ipk_pkg::ST_ON: begin
					if (tick) begin
						if (cnt_reg == on_len_reg - 9'h1) begin
							state_reg <= ipk_pkg::ST_OFF;
							cnt_reg <= 9'h0;
							keyed_output_out <= 1'b0;
							sidetone_gate_out <= 1'b0;
						end else begin
							cnt_reg <= cnt_reg + 9'h1;
						end
					end
				end
				ipk_pkg::ST_OFF: begin
					if (tick) begin
						if (cnt_reg == off_len_reg - 9'h1) begin
							state_reg <= ipk_pkg::ST_IDLE;
							done_reg <= 1'b1;
						end else begin
							cnt_reg <= cnt_reg + 9'h1;
						end
					end
				end
				default: begin
					state_reg <= ipk_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// element memories
	// ------------------------------------------------------------
	logic busy;
	logic start;
	assign busy = state_reg != ipk_pkg::ST_IDLE;
	assign start = !busy && (want_s || want_l);

	// latch the other paddle, set beats clear
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			short_mem_reg <= 1'b0;
			long_mem_reg <= 1'b0;
		end else begin
			if (!short_en) begin
				short_mem_reg <= 1'b0;
			end else if (busy && elem_long_reg && pad_deb_reg[0]) begin
				short_mem_reg <= 1'b1;
			end else if (start && !pick_long) begin
				short_mem_reg <= 1'b0;
			end
			if (!long_en) begin
				long_mem_reg <= 1'b0;
			end else if (busy && !elem_long_reg && pad_deb_reg[1]) begin
				long_mem_reg <= 1'b1;
			end else if (start && pick_long) begin
				long_mem_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	function automatic logic [31:0] rd_word(input logic [3:0] a);
		case (a)
			ipk_pkg::OFS_CTRL: rd_word = {29'h0, ctrl_reg};
			ipk_pkg::OFS_SPEED: rd_word = {25'h0, speed_reg};
			ipk_pkg::OFS_WEIGHT: rd_word = {18'h0, light_reg, 2'h0, heavy_reg};
			ipk_pkg::OFS_STATUS: rd_word = {16'h0, weight_reg, pad_deb_reg,
				state_reg, long_mem_reg, short_mem_reg, elem_long_reg,
				keyed_output_out};
			default: rd_word = 32'h0;
		endcase
	endfunction

	logic do_write;
	assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid_out;

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= ipk_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awready_out && s_axi_awvalid_in) begin
				s_axi_awready_out <= 1'b0;
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_in;
			end else if (!aw_hold_reg && !s_axi_bvalid_out) begin
				s_axi_awready_out <= 1'b1;
			end
			if (s_axi_wready_out && s_axi_wvalid_in) begin
				s_axi_wready_out <= 1'b0;
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata_in;
				w_strb_reg <= s_axi_wstrb_in;
			end else if (!w_hold_reg && !s_axi_bvalid_out) begin
				s_axi_wready_out <= 1'b1;
			end
			if (do_write) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= (aw_addr_reg[1:0] != 2'h0 ||
					aw_addr_reg == ipk_pkg::OFS_STATUS) ?
					ipk_pkg::RESP_SLVERR : ipk_pkg::RESP_OKAY;
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// control registers, byte lanes 0 and 1
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_reg <= ipk_pkg::CTRL_RESET;
			speed_reg <= ipk_pkg::SPEED_RESET;
			heavy_reg <= ipk_pkg::ADJ_RESET;
			light_reg <= ipk_pkg::ADJ_RESET;
		end else if (do_write) begin
			case (aw_addr_reg)
				ipk_pkg::OFS_CTRL:
					if (w_strb_reg[0]) ctrl_reg <= w_data_reg[2:0];
				ipk_pkg::OFS_SPEED:
					if (w_strb_reg[0]) speed_reg <= w_data_reg[6:0];
				ipk_pkg::OFS_WEIGHT: begin
					if (w_strb_reg[0]) heavy_reg <= w_data_reg[5:0];
					if (w_strb_reg[1]) light_reg <= w_data_reg[13:8];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0;
			s_axi_rresp_out <= ipk_pkg::RESP_OKAY;
		end else if (s_axi_arready_out && s_axi_arvalid_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= rd_word(s_axi_araddr_in);
			s_axi_rresp_out <= (s_axi_araddr_in[1:0] != 2'h0) ?
				ipk_pkg::RESP_SLVERR : ipk_pkg::RESP_OKAY;
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end else if (!s_axi_rvalid_out) begin
			s_axi_arready_out <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	sequence seq_on_end;
		state_reg == ipk_pkg::ST_ON && tick && cnt_reg == on_len_reg - 9'h1;
	endsequence
	sequence seq_off_end;
		state_reg == ipk_pkg::ST_OFF && tick && cnt_reg == off_len_reg - 9'h1;
	endsequence

	chk_tone_follows: assert property (sidetone_gate_out == keyed_output_out)
		else $error("sidetone gate differs from key");
	chk_base_stopped: assert property (!busy |=> acc_reg == 20'h0)
		else $error("timebase runs while idle");
	chk_key_release: assert property (seq_on_end |=> !keyed_output_out
		&& state_reg == ipk_pkg::ST_OFF)
		else $error("key not released at end of on time");
	chk_self_complete: assert property (seq_off_end |=> done_reg
		&& state_reg == ipk_pkg::ST_IDLE)
		else $error("element did not complete");
	chk_period_const: assert property (busy |-> on_len_reg + off_len_reg ==
		(elem_long_reg ? 9'h190 : ipk_pkg::ELEM_PERIOD))
		else $error("element period not constant");
	chk_short_latch: assert property (busy && elem_long_reg && pad_deb_reg[0]
		&& short_en |=> short_mem_reg)
		else $error("short closure not latched");
	chk_short_ignored: assert property (!short_en |=> !short_mem_reg)
		else $error("short memory set while disabled");
	chk_long_latch: assert property (busy && !elem_long_reg && pad_deb_reg[1]
		&& long_en |=> long_mem_reg)
		else $error("long closure not latched");
	chk_short_follows: assert property (!busy && short_mem_reg |=>
		state_reg == ipk_pkg::ST_ON && !elem_long_reg)
		else $error("latched short not sent next");
	chk_iambic_alt: assert property (start && short_en && long_en && want_s
		&& want_l && last_valid_reg |=>
		elem_long_reg == !$past(last_long_reg))
		else $error("squeeze did not alternate");
	chk_fixed_ratio: assert property (!ctrl_reg[ipk_pkg::CTRL_WEIGHT_MODE]
		&& $stable(heavy_reg) && $stable(light_reg) && $stable(ctrl_reg)
		|-> weight_reg == ipk_pkg::WEIGHT_CLASSIC + heavy - light)
		else $error("fixed weight drifts");
endmodule
`default_nettype wire

/* testbench/ipk_paddle_model.sv */
/*
 * Operator paddle and key-line model for the keyer bench.
 * Assumes bench commands change right after a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module ipk_paddle_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// bench commands and key line
	input wire logic short_cmd_in,
	input wire logic long_cmd_in,
	input wire logic key_in,
	input wire logic tone_in,
	// paddle contacts
	output logic short_paddle_out,
	output logic long_paddle_out
);
	int on_len[$];
	int gap_len[$];
	int run = 0;
	int tone_errs = 0;
	logic key_d = 1'b0;
	logic s_q = 1'b0;
	logic l_q = 1'b0;
	logic [1:0] s_d = 2'h0;
	logic [1:0] l_d = 2'h0;
	assign short_paddle_out = s_q;
	assign long_paddle_out = l_q;
	// ------------------------------------------------------------
	// contacts
	// ------------------------------------------------------------
	// a closing contact chatters open for one cycle after first touch,
	// so the debounce in front of the keyer is really exercised
	always @(posedge clk_in) begin
		if (!rstn_in) begin
			s_d <= 2'h0;
			l_d <= 2'h0;
			s_q <= 1'b0;
			l_q <= 1'b0;
		end else begin
			s_d <= {s_d[0], short_cmd_in};
			l_d <= {l_d[0], long_cmd_in};
			s_q <= short_cmd_in && (s_d != 2'b01);
			l_q <= long_cmd_in && (l_d != 2'b01);
		end
	end
	// ------------------------------------------------------------
	// key line monitor
	// ------------------------------------------------------------
	task clear();
		on_len.delete();
		gap_len.delete();
		run = 0;
	endtask
	always @(posedge clk_in) begin
		if (tone_in !== key_in) begin
			tone_errs++;
		end
		if (key_in !== key_d) begin
			if (key_d === 1'b1) begin
				on_len.push_back(run);
			end else begin
				gap_len.push_back(run);
			end
			run = 0;
		end
		run++;
		key_d = key_in;
	end
endmodule
`default_nettype wire

/* testbench/tb_iambic_paddle_keyer.sv */
/*
 * Self-checking bench for the paddle keyer: registers over AXI4-Lite,
 * element timing and memories through the paddle model.
 * Assumes shortened counts: CENTI_NUM 100, debounce 2 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
	checks_done++; \
	if ((a) !== (b)) begin \
		n_errors++; \
		$display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); \
	end \
end
module tb_iambic_paddle_keyer;
	localparam logic [1:0] OK = ipk_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = ipk_pkg::RESP_SLVERR;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic short_cmd = 1'b0, long_cmd = 1'b0;
	logic short_pad, long_pad, key, tone;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int sp[4] = '{50, 50, 25, 50};
	int hv[4] = '{0, 20, 20, 0};
	int lt[4] = '{0, 0, 0, 30};
	int eon[4] = '{200, 240, 480, 140};
	int eper[4] = '{400, 400, 800, 400};

	ipk_keyer #(.FAST_SPEED(1'b0), .CENTI_NUM(100), .DEBOUNCE_CYC(2))
	ipk_keyer_inst (.core_clk_in(clk), .rstn_in(rstn),
		.short_paddle_in(short_pad), .long_paddle_in(long_pad),
		.keyed_output_out(key), .sidetone_gate_out(tone),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready));

	ipk_paddle_model paddle_model_inst (.clk_in(clk), .rstn_in(rstn),
		.short_cmd_in(short_cmd), .long_cmd_in(long_cmd), .key_in(key),
		.tone_in(tone), .short_paddle_out(short_pad),
		.long_paddle_out(long_pad));

	initial begin
		forever #20 clk = ~clk;
	end
	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		bit aw;
		bit w;
		aw = 0;
		w = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1 && !aw) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1 && !w) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end while (!(aw && w));
		do @(posedge clk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wo(input logic [3:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		`CHK(r, OK)
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		`CHK(d, e)
		`CHK(r, er)
	endtask
	// ------------------------------------------------------------
	// paddle sequences
	// ------------------------------------------------------------
	function automatic int near(input int v, input int e);
		return ((v - e) <= e / 32 + 4 && (e - v) <= e / 32 + 4) ? e : v;
	endfunction
	// closes each paddle over [x0, x1) cycles, then lets elements finish;
	// pat bit i is 1 where element i must be a long one
	task automatic play(input logic [2:0] c, input int s0, s1, l0, l1,
		input int nmin, nmax, k, input logic [7:0] pat);
		int i;
		int n;
		wo(ipk_pkg::OFS_CTRL, {29'h0, c});
		paddle_model_inst.clear();
		for (i = 0; i < 3200 + (s1 > l1 ? s1 : l1); i++) begin
			short_cmd <= (i >= s0 && i < s1);
			long_cmd <= (i >= l0 && i < l1);
			@(posedge clk);
		end
		n = paddle_model_inst.on_len.size();
		`CHK((n >= nmin && n <= nmax) ? nmin : n, nmin)
		for (i = 0; i < k; i++) begin
			`CHK(paddle_model_inst.on_len[i] > 400, pat[i])
		end
	endtask
	// ------------------------------------------------------------
	// verdict and watchdog
	// ------------------------------------------------------------
	task print_verdict();
		if (n_errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			n_errors++;
			print_verdict();
		end
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int j;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rchk(ipk_pkg::OFS_CTRL, 32'h3, OK);
		rchk(ipk_pkg::OFS_SPEED, 32'h14, OK);
		rchk(ipk_pkg::OFS_WEIGHT, 32'h0, OK);
		rchk(4'h1, 32'h0, ERR);
		wr(ipk_pkg::OFS_STATUS, 32'h1, r);
		`CHK(r, ERR)
		wo(ipk_pkg::OFS_SPEED, 32'h64);
		rchk(ipk_pkg::OFS_SPEED, 32'h64, OK);
		wo(ipk_pkg::OFS_SPEED, 32'h2);
		rchk(ipk_pkg::OFS_SPEED, 32'h2, OK);
		// fixed mode: heavy only, same weight at both speed ends
		wo(ipk_pkg::OFS_WEIGHT, 32'h14);
		wo(ipk_pkg::OFS_CTRL, 32'h0);
		for (j = 0; j < 2; j++) begin
			wo(ipk_pkg::OFS_SPEED, j ? 32'h32 : 32'h6);
			rd(ipk_pkg::OFS_STATUS, d, r);
			`CHK(d[15:8], 8'h78)
		end
		// auto mode: heavy end at slow speed, light end at top speed;
		// out-of-range speeds must act as the clamped ends
		wo(ipk_pkg::OFS_WEIGHT, 32'h1E14);
		wo(ipk_pkg::OFS_CTRL, 32'h4);
		for (j = 0; j < 2; j++) begin
			wo(ipk_pkg::OFS_SPEED, j ? 32'h64 : 32'h2);
			rd(ipk_pkg::OFS_STATUS, d, r);
			`CHK(d[15:8], j ? 8'h46 : 8'h78)
		end
		for (j = 0; j < 4; j++) begin
			wo(ipk_pkg::OFS_SPEED, sp[j]);
			wo(ipk_pkg::OFS_WEIGHT, (lt[j] << 8) | hv[j]);
			play(3'h0, 0, eper[j] + 300, 0, 0, 2, 2, 0, 8'h0);
			`CHK(near(paddle_model_inst.on_len[0], eon[j]), eon[j])
			`CHK(near(paddle_model_inst.on_len[0] +
				paddle_model_inst.gap_len[1], eper[j]), eper[j])
			`CHK(paddle_model_inst.gap_len[0] < 16, 1'b1)
		end
		wo(ipk_pkg::OFS_WEIGHT, 32'h0);
		play(3'h0, 0, 0, 0, 10, 1, 1, 1, 8'h01);
		`CHK(near(paddle_model_inst.on_len[0], 600), 600)
		play(3'h0, 0, 1, 0, 0, 0, 0, 0, 8'h00);
		play(3'h1, 1000, 1020, 0, 2100, 4, 4, 4, 8'h0B);
		play(3'h0, 1000, 1020, 0, 2100, 3, 3, 3, 8'h07);
		play(3'h1, 0, 1000, 0, 1000, 3, 6, 3, 8'h00);
		play(3'h1, 50, 1500, 0, 1500, 3, 6, 3, 8'h01);
		play(3'h2, 0, 1500, 100, 120, 3, 6, 3, 8'h02);
		play(3'h3, 0, 1500, 50, 1500, 4, 8, 4, 8'h0A);
		play(3'h3, 50, 1500, 0, 1500, 4, 8, 4, 8'h05);
		`CHK(paddle_model_inst.tone_errs, 0)
		print_verdict();
	end
endmodule
`default_nettype wire
